// ==== common/psi_pkg.sv ====
// shared constants and types for the transceiver status and identity registers
package psi_pkg;

  // register addresses on the management interface
  localparam logic [4:0]  PSI_REG_CTRL   = 5'h00;
  localparam logic [4:0]  PSI_REG_STATUS = 5'h01;
  localparam logic [4:0]  PSI_REG_ID_HI  = 5'h02;
  localparam logic [4:0]  PSI_REG_ID_LO  = 5'h03;

  // status register default and the mask of its constant bits (15..6 and 0)
  localparam logic [15:0] PSI_STATUS_RESET = 16'h7849;
  localparam logic [15:0] PSI_FIXED_MASK   = 16'hFFC1;

  // status bit positions
  localparam int PSI_BIT_T4   = 15;
  localparam int PSI_BIT_TXFD = 14;
  localparam int PSI_BIT_THD  = 11;
  localparam int PSI_BIT_RSVH = 10;
  localparam int PSI_BIT_RSVL = 7;
  localparam int PSI_BIT_PRE  = 6;
  localparam int PSI_BIT_ANC  = 5;
  localparam int PSI_BIT_RF   = 4;
  localparam int PSI_BIT_HIST = 3;
  localparam int PSI_BIT_LINK = 2;
  localparam int PSI_BIT_JAB  = 1;
  localparam int PSI_BIT_EXT  = 0;

  // self-clearing software reset bit of the control register
  localparam int PSI_BIT_SWRST = 15;

  // frame opcodes
  localparam logic [1:0]  PSI_OP_READ  = 2'h2;
  localparam logic [1:0]  PSI_OP_WRITE = 2'h1;

  // last bit index of each frame phase (counted in mdc rising edges)
  localparam logic [4:0]  PSI_HDR_LAST    = 5'h0C;
  localparam logic [4:0]  PSI_DATA_LAST   = 5'h10;
  localparam logic [4:0]  PSI_LISTEN_LAST = 5'h11;

  // identity value, arbitrary
  localparam logic [31:0] PSI_ID_DEFAULT = 32'h0012_3450;

  typedef enum logic [4:0] {
    PSI_ST_IDLE    = 5'b00001,
    PSI_ST_HDR     = 5'b00010,
    PSI_ST_TA_RD   = 5'b00100,
    PSI_ST_DATA_RD = 5'b01000,
    PSI_ST_LISTEN  = 5'b10000
  } psi_state_t;

endpackage

// ==== design/psi_status_bank.sv ====
// status register bank: live, latch-high, latch-low and history bits
module psi_status_bank
  import psi_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        soft_rst,
  input  wire logic        rd_clr,
  input  wire logic        an_complete,
  input  wire logic        remote_fault,
  input  wire logic        link_up,
  input  wire logic        jabber,
  input  wire logic        link_fail,
  output logic [15:0]      status
);

  logic an_q,   an_d;
  logic rf_q,   rf_d;
  logic jab_q,  jab_d;
  logic link_q, link_d;
  logic hist_q, hist_d;

  // next values; an event in the read cycle beats the read clear
  always_comb
  begin
    an_d   = an_complete;
    rf_d   = remote_fault | (rf_q & ~rd_clr);
    jab_d  = jabber | (jab_q & ~rd_clr);
    link_d = rd_clr ? link_up : (link_q & link_up);
    hist_d = hist_q & ~link_fail;
    if (soft_rst)
    begin
      // software reset returns every dynamic bit to its default
      an_d   = PSI_STATUS_RESET[PSI_BIT_ANC];
      rf_d   = PSI_STATUS_RESET[PSI_BIT_RF];
      jab_d  = PSI_STATUS_RESET[PSI_BIT_JAB];
      link_d = PSI_STATUS_RESET[PSI_BIT_LINK];
      hist_d = PSI_STATUS_RESET[PSI_BIT_HIST];
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      an_q   <= PSI_STATUS_RESET[PSI_BIT_ANC];
      rf_q   <= PSI_STATUS_RESET[PSI_BIT_RF];
      jab_q  <= PSI_STATUS_RESET[PSI_BIT_JAB];
      link_q <= PSI_STATUS_RESET[PSI_BIT_LINK];
      hist_q <= PSI_STATUS_RESET[PSI_BIT_HIST];
    end
    else
    begin
      an_q   <= an_d;
      rf_q   <= rf_d;
      jab_q  <= jab_d;
      link_q <= link_d;
      hist_q <= hist_d;
    end
  end

  // constant ability, reserved and extended bits come straight from the default
  always_comb
  begin
    status               = PSI_STATUS_RESET & PSI_FIXED_MASK;
    status[PSI_BIT_ANC]  = an_q;
    status[PSI_BIT_RF]   = rf_q;
    status[PSI_BIT_HIST] = hist_q;
    status[PSI_BIT_LINK] = link_q;
    status[PSI_BIT_JAB]  = jab_q;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  no_t4_a:       assert property (!status[PSI_BIT_T4])
    else $error("t4 ability bit not zero");
  abilities_a:   assert property (status[PSI_BIT_TXFD:PSI_BIT_THD] == 4'hF)
    else $error("ability bits not all one");
  preamble_a:    assert property (status[PSI_BIT_PRE])
    else $error("preamble suppression bit not one");
  reserved_ext_a: assert property (status[PSI_BIT_RSVH:PSI_BIT_RSVL] == 4'h0
                                   && status[PSI_BIT_EXT])
    else $error("reserved or extended bit wrong");
  an_track_a:    assert property (!soft_rst |=> status[PSI_BIT_ANC] == $past(an_complete))
    else $error("auto-negotiation complete does not track");
  rf_hold_a:     assert property (remote_fault && !soft_rst
                                  |=> status[PSI_BIT_RF] until_with (rd_clr || soft_rst))
    else $error("remote fault not held until read");
  rf_clear_a:    assert property (rd_clr && !remote_fault && !soft_rst
                                  |=> !status[PSI_BIT_RF])
    else $error("remote fault not cleared by read");
  history_a:     assert property ((link_fail && !soft_rst) ##1 !soft_rst[*3]
                                  |-> !status[PSI_BIT_HIST])
    else $error("link failure history lost");
  link_low_a:    assert property (!link_up ##1 (!rd_clr && !soft_rst)
                                  |-> !status[PSI_BIT_LINK])
    else $error("link loss not latched low");
  jabber_a:      assert property (jabber |=> status[PSI_BIT_JAB] || $past(soft_rst))
    else $error("jabber not latched high");
  resume_a:      assert property (rd_clr && link_up && !soft_rst
                                  |=> status[PSI_BIT_LINK])
    else $error("link bit does not resume after read");
  soft_reset_a:  assert property (soft_rst |=> status == PSI_STATUS_RESET)
    else $error("software reset did not restore status default");

endmodule

// ==== design/psi_mgmt_top.sv ====
// management-interface slave serving the status and identity registers
module psi_mgmt_top
  import psi_pkg::*;
#(
  parameter logic [4:0]  PHY_ADDR = 5'h01,
  parameter logic [31:0] ID_VALUE = PSI_ID_DEFAULT,
  parameter bit          ID_ZERO  = 1'b0
)
(
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic mdc,
  input  wire logic mdio_in,
  output logic      mdio_out,
  output logic      mdio_oe_n,
  input  wire logic an_complete,
  input  wire logic remote_fault,
  input  wire logic link_up,
  input  wire logic jabber,
  input  wire logic link_fail
);

  logic        rst_s1_q;
  logic        rst_n;
  logic        mdc_s1_q;
  logic        mdc_s2_q;
  logic        mdc_s3_q;
  logic        mdio_s1_q;
  logic        mdio_s2_q;
  logic        rise;
  logic        bit_in;
  psi_state_t  state_q,  state_d;
  logic [4:0]  cnt_q,    cnt_d;
  logic [11:0] hdr_q,    hdr_d;
  logic [15:0] shift_q,  shift_d;
  logic        own_q,    own_d;
  logic        rd_q,     rd_d;
  logic [4:0]  reg_q,    reg_d;
  logic        out_q,    out_d;
  logic        oe_n_q,   oe_n_d;
  logic        rd_clr;
  logic        soft_rst;
  logic [15:0] status;
  logic [15:0] id_hi;
  logic [15:0] id_lo;
  logic [12:0] full;
  logic [15:0] wword;
  logic [15:0] rdata;

  // reset release through two flops; assertion stays asynchronous
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rst_s1_q <= 1'b0;
      rst_n    <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_n    <= rst_s1_q;
    end
  end

  // mdc and mdio are asynchronous pins; the third mdc flop only feeds the edge detect
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mdc_s1_q  <= 1'b0;
      mdc_s2_q  <= 1'b0;
      mdc_s3_q  <= 1'b0;
      mdio_s1_q <= 1'b1;
      mdio_s2_q <= 1'b1;
    end
    else
    begin
      mdc_s1_q  <= mdc;
      mdc_s2_q  <= mdc_s1_q;
      mdc_s3_q  <= mdc_s2_q;
      mdio_s1_q <= mdio_in;
      mdio_s2_q <= mdio_s1_q;
    end
  end

  assign rise   = mdc_s2_q & ~mdc_s3_q;
  assign bit_in = mdio_s2_q;

  // fixed identity; the zero option trades recognition for anonymity
  assign id_hi = ID_ZERO ? 16'h0000 : ID_VALUE[31:16];
  assign id_lo = ID_ZERO ? 16'h0000 : ID_VALUE[15:0];

  assign full  = {hdr_q, bit_in};
  assign wword = {shift_q[14:0], bit_in};

  // read mux over the header's register field; unmapped and control read as zero
  always_comb
  begin
    case (full[4:0])
      PSI_REG_STATUS: rdata = status;
      PSI_REG_ID_HI:  rdata = id_hi;
      PSI_REG_ID_LO:  rdata = id_lo;
      default:        rdata = 16'h0000;
    endcase
  end

  // frame engine, advanced once per synchronised mdc rising edge
  always_comb
  begin
    state_d  = state_q;
    cnt_d    = cnt_q;
    hdr_d    = hdr_q;
    shift_d  = shift_q;
    own_d    = own_q;
    rd_d     = rd_q;
    reg_d    = reg_q;
    out_d    = out_q;
    oe_n_d   = oe_n_q;
    rd_clr   = 1'b0;
    soft_rst = 1'b0;
    if (rise)
    begin
      case (state_q)
        PSI_ST_IDLE:
        begin
          // any zero after idle ones starts a frame, preamble or not
          if (!bit_in)
          begin
            state_d = PSI_ST_HDR;
            cnt_d   = 5'h00;
          end
        end
        PSI_ST_HDR:
        begin
          hdr_d = full[11:0];
          cnt_d = cnt_q + 5'h01;
          if (cnt_q == PSI_HDR_LAST)
          begin
            cnt_d = 5'h00;
            reg_d = full[4:0];
            rd_d  = (full[11:10] == PSI_OP_READ);
            own_d = full[12] && (full[9:5] == PHY_ADDR)
                    && (full[11:10] == PSI_OP_READ || full[11:10] == PSI_OP_WRITE);
            if (own_d && rd_d)
            begin
              // snapshot and clear happen in the same cycle so no event slips between
              state_d = PSI_ST_TA_RD;
              shift_d = rdata;
              rd_clr  = (full[4:0] == PSI_REG_STATUS);
            end
            else
            begin
              state_d = PSI_ST_LISTEN;
            end
          end
        end
        PSI_ST_TA_RD:
        begin
          // second turnaround bit is driven low
          oe_n_d  = 1'b0;
          out_d   = 1'b0;
          state_d = PSI_ST_DATA_RD;
        end
        PSI_ST_DATA_RD:
        begin
          cnt_d = cnt_q + 5'h01;
          if (cnt_q == PSI_DATA_LAST)
          begin
            oe_n_d  = 1'b1;
            out_d   = 1'b0;
            state_d = PSI_ST_IDLE;
          end
          else
          begin
            out_d   = shift_q[15];
            shift_d = {shift_q[14:0], 1'b0};
          end
        end
        PSI_ST_LISTEN:
        begin
          // writes, and frames for other addresses, are received without driving
          shift_d = wword;
          cnt_d   = cnt_q + 5'h01;
          if (cnt_q == PSI_LISTEN_LAST)
          begin
            state_d  = PSI_ST_IDLE;
            soft_rst = own_q && !rd_q && (reg_q == PSI_REG_CTRL)
                       && wword[PSI_BIT_SWRST];
          end
        end
        default:
        begin
          state_d = PSI_ST_IDLE;
          oe_n_d  = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= PSI_ST_IDLE;
      cnt_q   <= 5'h00;
      hdr_q   <= 12'h000;
      shift_q <= 16'h0000;
      own_q   <= 1'b0;
      rd_q    <= 1'b0;
      reg_q   <= 5'h00;
      out_q   <= 1'b0;
      oe_n_q  <= 1'b1;
    end
    else
    begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      hdr_q   <= hdr_d;
      shift_q <= shift_d;
      own_q   <= own_d;
      rd_q    <= rd_d;
      reg_q   <= reg_d;
      out_q   <= out_d;
      oe_n_q  <= oe_n_d;
    end
  end

  assign mdio_out  = out_q;
  assign mdio_oe_n = oe_n_q;

  psi_status_bank u_bank (
    .clk          (clk),
    .rst_n        (rst_n),
    .soft_rst     (soft_rst),
    .rd_clr       (rd_clr),
    .an_complete  (an_complete),
    .remote_fault (remote_fault),
    .link_up      (link_up),
    .jabber       (jabber),
    .link_fail    (link_fail),
    .status       (status)
  );

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  id_word_a:     assert property ({id_hi, id_lo} == (ID_ZERO ? 32'h0000_0000 : ID_VALUE))
    else $error("identity word wrong");
  id_stable_a:   assert property ($stable(id_hi) && $stable(id_lo))
    else $error("identity register changed");
  read_clear_a:  assert property (rd_clr |-> state_q == PSI_ST_HDR && rise
                                  && full[4:0] == PSI_REG_STATUS)
    else $error("status clear outside a status read");
  swrst_frame_a: assert property (soft_rst |-> state_q == PSI_ST_LISTEN && !rd_q
                                  && reg_q == PSI_REG_CTRL)
    else $error("software reset outside a control write");
  ta_drive_a:    assert property (rise && state_q == PSI_ST_TA_RD
                                  |=> !mdio_oe_n && !mdio_out)
    else $error("turnaround not driven low");

  status_rd_c:   cover property (rd_clr);
  swrst_c:       cover property (soft_rst);
  id_read_c:     cover property (state_q == PSI_ST_TA_RD && reg_q == PSI_REG_ID_LO);
  foreign_c:     cover property (state_q == PSI_ST_LISTEN && !own_q);

endmodule

// ==== tb/psi_mgmt_master.sv ====
// station management master model: clocks frames onto mdc and mdio
module psi_mgmt_master
  import psi_pkg::*;
(
  input  wire logic clk,
  input  wire logic mdio_wire,
  output logic      mdc,
  output logic      m_out,
  output logic      m_en
);
  timeunit 1ns;
  timeprecision 1ps;

  // 12 clk per mdc phase keeps both phases well above the sync filter
  localparam int HALF = 12;

  // mdc stands low and mdio is released outside frames
  initial
  begin
    mdc   = 1'b0;
    m_out = 1'b1;
    m_en  = 1'b0;
  end

  // one bit: set mdio in the low phase, sample the wire as mdc rises
  task automatic bit_cycle(input logic en, input logic val, output logic seen);
    m_en  = en;
    m_out = val;
    repeat (HALF) @(negedge clk);
    seen = mdio_wire;
    mdc  = 1'b1;
    repeat (HALF) @(negedge clk);
    mdc  = 1'b0;
  endtask

  // whole frame; rd[16] is the second turnaround bit, rd[15:0] the data seen
  task automatic frame(input  logic [1:0]  op,
                       input  logic [4:0]  phy,
                       input  logic [4:0]  rg,
                       input  logic [15:0] wd,
                       input  int          pre,
                       output logic [16:0] rd);
    logic [31:0] word;
    logic        s;
    logic        rdop;
    word = {2'b01, op, phy, rg, 2'b10, wd};
    // anything but a write leaves turnaround and data to the slave
    rdop = (op != PSI_OP_WRITE);
    for (int i = 0; i < pre; i++)
      bit_cycle(1'b1, 1'b1, s);
    for (int i = 31; i >= 0; i--)
    begin
      bit_cycle(!(rdop && i < 18), word[i], s);
      if (i < 17)
        rd[i] = s;
    end
    bit_cycle(1'b0, 1'b1, s);
  endtask
endmodule

// ==== tb/psi_mgmt_top_tb.sv ====
// self-checking bench for the status and identity register slave
module psi_mgmt_top_tb
  import psi_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [4:0] PHY   = 5'h01;
  // address of the second slave, built to read an all-zero identity
  localparam logic [4:0] PHY_Z = 5'h02;

  logic clk = 1'b0;
  logic resetn;
  logic mdc;
  logic m_out;
  logic m_en;
  logic mdio_wire;
  logic mdio_out;
  logic mdio_oe_n;
  logic mdio_out_z;
  logic mdio_oe_n_z;
  logic an_complete;
  logic remote_fault;
  logic link_up;
  logic jabber;
  logic link_fail;
  int   err_count = 0;
  int   cmp_count = 0;
  // expected latch state of the status register
  logic hist;
  logic rf_l;
  logic jab_l;
  logic link_ok;

  always #2 clk = ~clk;

  // pulled-up wire: low when the master or either slave drives a zero
  assign mdio_wire = (m_en ? m_out : 1'b1) & (mdio_oe_n ? 1'b1 : mdio_out)
                     & (mdio_oe_n_z ? 1'b1 : mdio_out_z);

  psi_mgmt_top #(.PHY_ADDR(PHY)) dut (
    .clk          (clk),
    .resetn       (resetn),
    .mdc          (mdc),
    .mdio_in      (mdio_wire),
    .mdio_out     (mdio_out),
    .mdio_oe_n    (mdio_oe_n),
    .an_complete  (an_complete),
    .remote_fault (remote_fault),
    .link_up      (link_up),
    .jabber       (jabber),
    .link_fail    (link_fail)
  );

  // second slave on the same wire; only frames to its own address wake it
  psi_mgmt_top #(.PHY_ADDR(PHY_Z), .ID_ZERO(1'b1)) dut_zero (
    .clk          (clk),
    .resetn       (resetn),
    .mdc          (mdc),
    .mdio_in      (mdio_wire),
    .mdio_out     (mdio_out_z),
    .mdio_oe_n    (mdio_oe_n_z),
    .an_complete  (an_complete),
    .remote_fault (remote_fault),
    .link_up      (link_up),
    .jabber       (jabber),
    .link_fail    (link_fail)
  );

  psi_mgmt_master mm (
    .clk       (clk),
    .mdio_wire (mdio_wire),
    .mdc       (mdc),
    .m_out     (m_out),
    .m_en      (m_en)
  );

  task automatic check(input string name, input logic [16:0] seen, input logic [16:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic finish_test();
    if (err_count == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // fixed ability bits plus the modelled live and latched bits
  function automatic logic [16:0] exp_status();
    return {1'b0, 16'h7841 | {10'h000, an_complete, rf_l, hist, link_ok, jab_l, 1'b0}};
  endfunction

  function automatic void model_reset();
    hist    = 1'b1;
    rf_l    = 1'b0;
    jab_l   = 1'b0;
    link_ok = 1'b0;
  endfunction

  // a served status read: turnaround zero, then the register; latches then rearm
  task automatic rd_status(input int pre);
    logic [16:0] got;
    mm.frame(PSI_OP_READ, PHY, PSI_REG_STATUS, 16'h0000, pre, got);
    check("status", got, exp_status());
    rf_l    = 1'b0;
    jab_l   = 1'b0;
    link_ok = link_up;
  endtask

  task automatic rd_reg(input string name, input logic [4:0] phy, input logic [1:0] op,
                        input logic [4:0] rg, input logic [16:0] exp);
    logic [16:0] got;
    mm.frame(op, phy, rg, 16'h0000, 0, got);
    check(name, got, exp);
  endtask

  task automatic wr_reg(input logic [4:0] rg, input logic [15:0] wd);
    logic [16:0] got;
    mm.frame(PSI_OP_WRITE, PHY, rg, wd, 0, got);
  endtask

  // one-cycle event on a condition input, or a new link_up level that stays, between frames only
  task automatic event_pulse(input int ev);
    @(negedge clk);
    case (ev)
      0: remote_fault = 1'b1;
      1: jabber = 1'b1;
      2: link_fail = 1'b1;
      3: link_up = 1'b0;
      default: link_up = 1'b1;
    endcase
    @(negedge clk);
    remote_fault = 1'b0;
    jabber       = 1'b0;
    link_fail    = 1'b0;
    if (ev == 0) rf_l = 1'b1;
    if (ev == 1) jab_l = 1'b1;
    if (ev == 2) hist = 1'b0;
    if (ev == 3) link_ok = 1'b0;
    if (ev == 3) link_up = 1'($urandom_range(0, 1));
    repeat (3) @(negedge clk);
  endtask

  // watchdog sized well above the at most roughly 54k clk the sequence needs
  initial
  begin
    #400000;
    err_count++;
    finish_test();
  end

  initial
  begin
    resetn       = 1'b0;
    an_complete  = 1'b0;
    remote_fault = 1'b0;
    link_up      = 1'b0;
    jabber       = 1'b0;
    link_fail    = 1'b0;
    model_reset();
    void'($urandom(32'h89A2));
    repeat (5) @(negedge clk);
    resetn = 1'b1;
    rd_status(32);
    rd_reg("id high", PHY, PSI_OP_READ, PSI_REG_ID_HI, {1'b0, PSI_ID_DEFAULT[31:16]});
    rd_reg("id low", PHY, PSI_OP_READ, PSI_REG_ID_LO, {1'b0, PSI_ID_DEFAULT[15:0]});
    wr_reg(PSI_REG_ID_HI, 16'hFFFF);
    rd_reg("id high ro", PHY, PSI_OP_READ, PSI_REG_ID_HI, {1'b0, PSI_ID_DEFAULT[31:16]});
    rd_reg("zero id high", PHY_Z, PSI_OP_READ, PSI_REG_ID_HI, 17'h00000);
    rd_reg("zero id low", PHY_Z, PSI_OP_READ, PSI_REG_ID_LO, 17'h00000);
    // random conditions, each followed by one read without preamble and sometimes a second with 0 to 40 preamble bits
    for (int n = 0; n < 16; n++)
    begin
      an_complete = 1'($urandom_range(0, 1));
      event_pulse($urandom_range(0, 4));
      rd_status(0);
      if ($urandom_range(0, 1) == 1)
        rd_status($urandom_range(0, 40));
    end
    // refused frames must not answer, control and unmapped reads answer zero; none of these frames may clear the latched fault
    event_pulse(0);
    event_pulse(2);
    rd_reg("op 00", PHY, 2'b00, PSI_REG_STATUS, 17'h1FFFF);
    rd_reg("op 11", PHY, 2'b11, PSI_REG_STATUS, 17'h1FFFF);
    rd_reg("other phy", PHY ^ 5'h01, PSI_OP_READ, PSI_REG_STATUS, 17'h1FFFF);
    rd_reg("ctrl", PHY, PSI_OP_READ, PSI_REG_CTRL, 17'h00000);
    rd_reg("unmapped", PHY, PSI_OP_READ, 5'h1F, 17'h00000);
    wr_reg(PSI_REG_CTRL, 16'h7FFF);
    rd_status(0);
    // software reset restores defaults over latched jabber and lost history
    event_pulse(1);
    event_pulse(2);
    wr_reg(PSI_REG_CTRL, 16'h8000);
    model_reset();
    rd_status(0);
    finish_test();
  end
endmodule
